// File: rtl/rcdri_sequencer.sv
`timescale 1ns/1ps
module rcdri_sequencer (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // mode strap
    input  wire logic                          quad_select_mode_i,
    // controller side
    input  wire rcdri_pkg::rcdri_cmd_type      cmd_i,
    // memory side, chip selects
    output logic [rcdri_pkg::CS_WIDTH-1:0]     chip_select_out_n_o,
    output logic [rcdri_pkg::CS_WIDTH-1:0]     chip_select_out_oe_o,
    // memory side, clock enables
    output logic                               clk_en_out_a0_o,
    output logic                               clk_en_out_a1_o,
    output logic                               clk_en_out_b0_o,
    output logic                               clk_en_out_b1_o,
    // memory side, termination
    output logic [rcdri_pkg::ODT_WIDTH-1:0]    term_ctrl_out_o,
    output logic                               term_ctrl_out_oe_o,
    // memory side, command and address
    output logic [rcdri_pkg::CA_WIDTH-1:0]     cmd_addr_out_o,
    output logic                               cmd_addr_out_oe_o,
    // open-drain error pin
    output logic                               parity_error_out_n_o,
    output logic                               parity_error_out_n_oe_o,
    // status
    output logic                               low_power_o,
    output logic                               term_enable_o,
    output logic                               ready_o
);
    import rcdri_pkg::*;

    rcdri_state_type         state;
    rcdri_state_type         next_state;
    logic [CNT_WIDTH-1:0]    count;
    logic                    quad_mode;
    rcdri_cmd_type           cmd_sync1;
    rcdri_cmd_type           cmd_sync2;

    // reset is deasserted only with clk running, so the first edge is
    // always a clocked release
    wire act_done  = (count >= CNT_WIDTH'(ACT_LEAD_CYCLES - 1));
    wire stab_done = (count >= CNT_WIDTH'(STAB_CYCLES - 1));
    wire in_active = (state == RCDRI_ACTIVE);
    wire in_reset  = (state == RCDRI_RESET);
    wire [CS_WIDTH-1:0] cs_mask = quad_mode ? 4'hF : 4'h3;
    wire [CS_WIDTH-1:0] cs_live = cmd_sync2.chip_select_n | ~cs_mask;
    wire one_cs = (cs_live != CS_IDLE_VALUE)
                && (((~cs_live) & ((~cs_live) - 4'h1)) == 4'h0);

    always_comb begin
        next_state = state;
        case (state)
            RCDRI_RESET:  next_state = RCDRI_WAKE;
            RCDRI_WAKE:   if (act_done) next_state = RCDRI_STAB;
            RCDRI_STAB:   if (stab_done) next_state = RCDRI_ACTIVE;
            RCDRI_ACTIVE: next_state = RCDRI_ACTIVE;
            default:      next_state = RCDRI_RESET;
        endcase
    end

    // async clear, nothing waits for a clock edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= RCDRI_RESET;
            count <= '0;
        end else begin
            state <= next_state;
            count <= (next_state != state) ? '0 : count + 1'b1;
        end
    end

    // strap caught after release, not under async reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            quad_mode <= 1'b0;
        end else if (in_reset) begin
            quad_mode <= quad_select_mode_i;
        end
    end

    // input receivers: two flops, held at idle (selects high, rest zero) while reset is high
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_sync1 <= '{CS_IDLE_VALUE, CKE_RST_VALUE, ODT_RST_VALUE,
                           CA_RST_VALUE};
            cmd_sync2 <= '{CS_IDLE_VALUE, CKE_RST_VALUE, ODT_RST_VALUE,
                           CA_RST_VALUE};
        end else begin
            cmd_sync1 <= cmd_i;
            cmd_sync2 <= cmd_sync1;
        end
    end

    // outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            chip_select_out_n_o     <= CS_IDLE_VALUE;
            chip_select_out_oe_o    <= '0;
            clk_en_out_a0_o         <= 1'b0;
            clk_en_out_a1_o         <= 1'b0;
            clk_en_out_b0_o         <= 1'b0;
            clk_en_out_b1_o         <= 1'b0;
            term_ctrl_out_o         <= ODT_RST_VALUE;
            term_ctrl_out_oe_o      <= 1'b0;
            cmd_addr_out_o          <= CA_RST_VALUE;
            cmd_addr_out_oe_o       <= 1'b0;
            parity_error_out_n_o    <= 1'b1;
            parity_error_out_n_oe_o <= 1'b0;          // released = high
            low_power_o             <= 1'b1;
            term_enable_o           <= 1'b0;
            ready_o                 <= 1'b0;
        end else begin
            low_power_o          <= 1'b0;
            term_enable_o        <= 1'b1;
            chip_select_out_oe_o <= cs_mask;
            term_ctrl_out_oe_o   <= 1'b1;
            cmd_addr_out_oe_o    <= 1'b1;
            ready_o              <= (next_state == RCDRI_ACTIVE);
            // odt follows input from the first edge on
            term_ctrl_out_o      <= cmd_sync2.term_ctrl;
            if (in_active) begin
                chip_select_out_n_o <= cs_live;
                clk_en_out_a0_o     <= cmd_sync2.clk_en[0];
                clk_en_out_b0_o     <= cmd_sync2.clk_en[0];
                clk_en_out_a1_o     <= cmd_sync2.clk_en[1];
                clk_en_out_b1_o     <= cmd_sync2.clk_en[1];
                if (one_cs) begin
                    cmd_addr_out_o <= cmd_sync2.cmd_addr;
                end
            end else begin
                chip_select_out_n_o <= CS_IDLE_VALUE;
            end
        end
    end

    a_cke_low_unready: assert property (@(posedge clk_i) disable iff (rst_i)
        !ready_o |-> !clk_en_out_a0_o && !clk_en_out_b1_o)
        else $error("clock enable high before ready");
    a_ready_after_stab: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ready_o) |-> $past(state) == RCDRI_STAB)
        else $error("ready without stabilization");
    a_low_power_off: assert property (@(posedge clk_i) disable iff (rst_i)
        ready_o |-> !low_power_o && term_enable_o)
        else $error("low power while ready");
    a_error_pin_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !ready_o |-> parity_error_out_n_o && !parity_error_out_n_oe_o)
        else $error("error pin active during init");
    a_cs_idle_pre: assert property (@(posedge clk_i) disable iff (rst_i)
        !ready_o |-> chip_select_out_n_o == CS_IDLE_VALUE)
        else $error("chip select passed before ready");
    a_odt_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 term_ctrl_out_o == $past(cmd_sync2.term_ctrl))
        else $error("termination not following input");
    a_cs_width_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        !in_reset |=> chip_select_out_oe_o == cs_mask)
        else $error("chip select width wrong for mode");
    a_count_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        state != $past(state) |-> count == '0)
        else $error("counter not restarted");

endmodule

// File: rtl/rcdri_pkg.sv
package rcdri_pkg;

    // timing figures and derived cycle counts
    localparam int CLK_FREQ_KHZ      = 25000;
    localparam int STAB_TIME_US      = 15;
    localparam int STAB_CYCLES       = (STAB_TIME_US * CLK_FREQ_KHZ) / 1000;
    localparam int ACT_LEAD_US       = 1;
    localparam int ACT_LEAD_CYCLES   = (ACT_LEAD_US * CLK_FREQ_KHZ) / 1000;
    localparam int CNT_WIDTH         = 16;

    // widths
    localparam int CS_WIDTH          = 4;
    localparam int CKE_WIDTH         = 2;
    localparam int ODT_WIDTH         = 2;
    localparam int CA_WIDTH          = 22;

    // reset values
    localparam logic [CS_WIDTH-1:0]  CS_IDLE_VALUE  = 4'hF;
    localparam logic [CKE_WIDTH-1:0] CKE_RST_VALUE  = 2'h0;
    localparam logic [ODT_WIDTH-1:0] ODT_RST_VALUE  = 2'h0;
    localparam logic [CA_WIDTH-1:0]  CA_RST_VALUE   = 22'h000000;

    // sequencer states
    typedef enum logic [3:0] {
        RCDRI_RESET  = 4'h1,
        RCDRI_WAKE   = 4'h2,
        RCDRI_STAB   = 4'h4,
        RCDRI_ACTIVE = 4'h8
    } rcdri_state_type;

    // inputs from the controller, one command cycle
    typedef struct packed {
        logic [CS_WIDTH-1:0]  chip_select_n;
        logic [CKE_WIDTH-1:0] clk_en;
        logic [ODT_WIDTH-1:0] term_ctrl;
        logic [CA_WIDTH-1:0]  cmd_addr;
    } rcdri_cmd_type;

endpackage

// File: bench/rcdri_ctrl_model.sv
`timescale 1ns/1ps
module rcdri_ctrl_model
    import rcdri_pkg::*;
(
    // clock and device status
    input  wire logic                    clk_i,
    input  wire logic                    ready_i,
    // command the bench wants sent
    input  wire rcdri_pkg::rcdri_cmd_type want_i,
    // to the device
    output rcdri_pkg::rcdri_cmd_type     cmd_o
);
    initial begin
        cmd_o = '0;
        cmd_o.chip_select_n = CS_IDLE_VALUE;
    end
    // selects idle and clock enables low until the device is ready
    always @(negedge clk_i) begin
        cmd_o <= want_i;
        if (!ready_i) begin
            cmd_o.chip_select_n <= CS_IDLE_VALUE;
            cmd_o.clk_en        <= CKE_RST_VALUE;
        end
    end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rcdri_pkg::*;
    logic          clk_i = 1'h0;
    logic          rst_i = 1'h1;
    logic          quad  = 1'h0;
    rcdri_cmd_type want  = '0;
    rcdri_cmd_type cmd;
    logic [3:0]    cs_o, cs_oe;
    logic [1:0]    t_o;
    logic [21:0]   ca_o;
    logic          a0, a1, b0, b1, t_oe, ca_oe, err, err_oe, lp, te, rdy;
    int            fails = 0, compares = 0, cycles = 0, n;

    rcdri_ctrl_model i_ctrl (.clk_i(clk_i), .ready_i(rdy), .want_i(want),
        .cmd_o(cmd));
    rcdri_sequencer i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .quad_select_mode_i(quad), .cmd_i(cmd), .chip_select_out_n_o(cs_o),
        .chip_select_out_oe_o(cs_oe), .clk_en_out_a0_o(a0),
        .clk_en_out_a1_o(a1), .clk_en_out_b0_o(b0), .clk_en_out_b1_o(b1),
        .term_ctrl_out_o(t_o), .term_ctrl_out_oe_o(t_oe),
        .cmd_addr_out_o(ca_o), .cmd_addr_out_oe_o(ca_oe),
        .parity_error_out_n_o(err), .parity_error_out_n_oe_o(err_oe),
        .low_power_o(lp), .term_enable_o(te), .ready_o(rdy));

    always #20 clk_i = ~clk_i;
    // whole run is about 820 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            stop_test();
        end
    end

    task check(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %0h seen %0h", name, exp, seen);
        end
    endtask

    task t_reset_state;
        check("cke", {a0, a1, b0, b1}, 32'h0);
        check("oe", {cs_oe, t_oe, ca_oe, err_oe}, 32'h0);
        check("err", err, 32'h1);
        check("power", {lp, te, rdy}, 32'h4);
    endtask

    // release, count edges to ready; chip selects stay idle and a0/b1 low meanwhile
    task bring_up;
        logic bad;
        bad = 1'h0;
        rst_i = 1'h0;
        #1 check("odt_pre", t_o, 32'h0);
        for (n = 0; n < 600 && rdy !== 1'h1; n++) begin
            @(negedge clk_i);
            bad = bad | a0 | b1 | (cs_o !== 4'hF);
        end
        check("idle", bad, 32'h0);
        check("lead", n >= ACT_LEAD_CYCLES + STAB_CYCLES, 32'h1);
        check("up", {t_oe, lp}, 32'h2);
    endtask

    task send(logic [3:0] cs, logic [1:0] ck, logic [1:0] od, logic [21:0] ca);
        want = '{cs, ck, od, ca};
        repeat (4) @(negedge clk_i);
    endtask

    task t_pass;
        send(4'hE, 2'h1, 2'h2, 22'h2AB5C3);
        check("ca", ca_o, 32'h2AB5C3);
        check("cke", {a0, a1, b0, b1}, 32'hA);
        check("cs", {cs_oe, cs_o}, 32'h3E);
        check("odt", t_o, 32'h2);
        send(4'hC, 2'h2, 2'h1, 22'h15A3C);
        check("ca_hold", ca_o, 32'h2AB5C3);
        check("cke2", {a0, a1, b0, b1}, 32'h5);
    endtask

    // reset lands between edges and must act at once
    task t_async;
        rst_i = 1'h1;
        #1 t_reset_state();
        @(negedge clk_i);
    endtask

    task t_quad;
        quad = 1'h1;
        want = '0;
        bring_up();
        send(4'h7, 2'h3, 2'h0, 22'h3C0F1);
        check("quad", {cs_oe, cs_o}, 32'hF7);
        check("ca_q", ca_o, 32'h3C0F1);
    endtask

    task stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (3) @(negedge clk_i);
        t_reset_state();
        bring_up();
        t_pass();
        t_async();
        t_quad();
        stop_test();
    end
endmodule
